// [src/dhc_pkg.sv]
`default_nettype none
package dhc_pkg;
  // Clock rate and power-on timing
  localparam int unsigned CLK_FREQ_KHZ = 100_000;
  localparam int unsigned RESET_HOLD_MS = 500;
  localparam int unsigned READY_DELAY_MS = 1000;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CLK_FREQ_KHZ;
  localparam int unsigned READY_DELAY_CYC = READY_DELAY_MS * CLK_FREQ_KHZ;
  localparam int unsigned TMR_W = 32;

  // Status byte bit positions
  localparam int SB_INPUT_READY = 0;
  localparam int SB_OUTPUT_READY = 1;
  localparam int SB_IDLE_N = 4;
  localparam int SB_BYTE_REQ = 5;
  localparam int SB_DIR = 6;
  localparam int SB_ATTENTION = 7;

  // Command byte fields
  localparam int CMD_CODE_LSB = 2;
  localparam int CMD_TRACK_BIT = 4;
  localparam int CMD_DIRECT_BIT = 5;
  localparam int CMD_SEEK_BIT = 6;
  localparam int CMD_NORETRY_BIT = 7;
  localparam logic [1:0] CLASS_NONXFER = 2'h1;
  localparam logic [1:0] CLASS_READ = 2'h2;
  localparam logic [1:0] CLASS_WRITE = 2'h3;

  // Class 1 command codes
  localparam logic [2:0] C1_DRIVE_STATUS = 3'h0;
  localparam logic [2:0] C1_SEEK = 3'h1;
  localparam logic [2:0] C1_READ_HDR = 3'h2;
  localparam logic [2:0] C1_RESTORE = 3'h3;
  localparam logic [2:0] C1_INIT = 3'h4;
  localparam logic [2:0] C1_VERIFY = 3'h5;
  localparam logic [2:0] C1_INIT_VFY = 3'h6;
  localparam logic [2:0] C1_FAULT_RESET = 3'h7;
  // Class 2 command codes
  localparam logic [1:0] C2_CORRECT = 2'h0;
  localparam logic [1:0] C2_NO_DATA_CHK = 2'h1;
  localparam logic [1:0] C2_NO_ADDR_CHK = 2'h2;

  // Command sequence and status
  localparam logic [2:0] GO_INDEX = 3'h7;
  localparam logic [3:0] AUX_LAST = 4'h7;
  localparam logic [7:0] TERM_OK = 8'h00;
  localparam logic [7:0] TERM_INVALID_CMD = 8'h01;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    ST_HOLD, ST_INIT, ST_IDLE, ST_RECV, ST_EXEC, ST_TERM_IDLE, ST_TERM_ATTENTION, ST_TERM_LOAD
  } dhc_state_t;
endpackage
`default_nettype wire

// [src/dhc_delay.sv]
`timescale 1ns/1ps
`default_nettype none
// Counter that restarts on demand, stops at the length and pulses once when the count reaches the length minus one
module dhc_delay #(
  parameter int W = 32
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic restart,
  input wire logic [W-1:0] len,
  output logic expired
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (restart) begin
      cnt_r <= '0;
    end else if (cnt_r != len) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Independent of restart, so a caller may restart on expiry without a loop
  assign expired = (cnt_r == len - 1'b1);
endmodule // dhc_delay
`default_nettype wire

// [src/dhc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// Byte FIFO with valid/ready on both sides
module dhc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clr) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dhc_fifo
`default_nettype wire

// [src/dhc_host_port.sv]
// Notes on behaviour
// - Input-ready sets on load, clears on data read
// - Output-ready sets on consume, clears on write
// - Control read returns status byte layout
// - Each command and parameter byte is echoed
// - Go byte of class 1-3 makes busy and starts execution
// - Termination: not-busy, attention, then status byte
// - Reading termination status clears attention
// - Up to seven auxiliary bytes follow termination
// - Control write while idle restarts reception
// - Hold reset 500 ms, ready one second later
// - Command bits 0-1 select the class
// - Seek-only starts seek and terminates at once
// - Read header reports address in aux 3-7
// - Restore returns drive to head and cylinder zero
// - Status, format, verify and fault reset codes
// - Class 1 seek and retry-disable bits
// - Class 2 track bit selects sector order
// - Class 2 direct bit selects transfer mode
// - Class 2 seek and retry-disable bits
// - Class 2 codes select check overrides
// - Write byte taken on strobe trailing edge
// - Direction flag zero for class 2, one class 3
`timescale 1ns/1ps
`default_nettype none
module dhc_host_port #(
  parameter int unsigned HOLD_CYC = dhc_pkg::RESET_HOLD_CYC,
  parameter int unsigned READY_CYC = dhc_pkg::READY_DELAY_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic iface_enable,
  input wire logic [7:0] bus_in,
  output logic [7:0] bus_out,
  output logic bus_oe,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic port_sel,
  output logic controller_idle_n,
  output logic attention,
  output logic byte_request,
  output logic transfer_direction,
  output logic exec_start,
  output logic [1:0] op_class,
  output logic [2:0] op_code,
  output logic op_seek,
  output logic op_retry_en,
  output logic op_track,
  output logic op_direct,
  output logic op_addr_chk,
  output logic op_data_chk,
  output logic op_correct,
  output logic op_drive_status,
  output logic op_read_hdr,
  output logic op_restore,
  output logic op_format,
  output logic op_verify,
  output logic op_fault_reset,
  output logic [47:0] op_params,
  input wire logic exec_done,
  input wire logic [7:0] exec_term,
  input wire logic [7:0] drive_status,
  input wire logic [3:0] hdr_head,
  input wire logic [7:0] hdr_cyl_lo,
  input wire logic [7:0] hdr_cyl_hi,
  input wire logic [7:0] hdr_sector,
  input wire logic [7:0] hdr_mark,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic rd_ready
);
  import dhc_pkg::*;

  dhc_state_t state_r;
  logic ws_d_r;
  logic rs_d_r;
  logic [7:0] wbyte_r;
  logic wsel_r;
  logic rsel_r;
  logic [7:0] cmd_r;
  logic [7:0] param_r [1:6];
  logic [2:0] idx_r;
  logic [3:0] aux_idx_r;
  logic [7:0] in_buf_r;
  logic [7:0] term_r;
  logic input_ready_r;
  logic output_ready_r;
  logic attention_r;
  logic term_pending_r;
  logic consume_r;
  logic done_seen_r;
  logic exec_start_r;
  logic tmr_exp;
  logic tmr_restart;
  logic [TMR_W-1:0] tmr_len;
  logic wr_evt;
  logic rd_evt;
  logic rd_data_evt;
  logic take_wr;
  logic ctrl_wr;
  logic data_wr;
  logic go_evt;
  logic go_valid;
  logic echo_evt;
  logic load_evt;
  logic [7:0] load_byte;
  logic [7:0] aux_byte;
  logic term_rd;
  logic aux_rd;
  logic xfer_active;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic seek_only;
  logic [7:0] status_byte;

  // Strobe edges, byte captured while the strobe is still high
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ws_d_r <= 1'b0;
      rs_d_r <= 1'b0;
      wbyte_r <= 8'h00;
      wsel_r <= 1'b0;
      rsel_r <= 1'b0;
    end else begin
      ws_d_r <= write_strobe;
      rs_d_r <= read_strobe;
      if (write_strobe) begin
        wbyte_r <= bus_in;
        wsel_r <= port_sel;
      end
      if (read_strobe) begin
        rsel_r <= port_sel;
      end
    end
  end

  assign wr_evt = ws_d_r && !write_strobe;
  assign rd_evt = rs_d_r && !read_strobe;
  assign rd_data_evt = rd_evt && rsel_r;
  assign take_wr = wr_evt && output_ready_r && (state_r == ST_IDLE || state_r == ST_RECV);
  assign ctrl_wr = take_wr && !wsel_r;
  assign data_wr = take_wr && wsel_r && (state_r == ST_RECV);
  assign go_evt = data_wr && (idx_r == GO_INDEX);
  assign go_valid = (cmd_r[1:0] != 2'h0);
  assign echo_evt = ctrl_wr || (data_wr && (idx_r != GO_INDEX));
  assign term_rd = rd_data_evt && term_pending_r;
  assign aux_rd = rd_data_evt && !term_pending_r && (aux_idx_r != 4'h0) && (state_r == ST_IDLE);
  assign xfer_active = (state_r == ST_EXEC) && (op_class == CLASS_READ);
  assign seek_only = (op_class == CLASS_NONXFER) && (op_code == C1_SEEK);

  // Power-on hold and ready delay
  assign tmr_restart = !iface_enable || ((state_r == ST_HOLD) && tmr_exp);
  assign tmr_len = (state_r == ST_HOLD) ? TMR_W'(HOLD_CYC) : TMR_W'(READY_CYC);

  dhc_delay #(.W(TMR_W)) u_delay (
    .core_clk(core_clk),
    .nrst(nrst),
    .restart(tmr_restart),
    .len(tmr_len),
    .expired(tmr_exp)
  );

  // Command sequencer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_HOLD;
      idx_r <= 3'h0;
      cmd_r <= 8'h00;
      term_r <= TERM_OK;
      exec_start_r <= 1'b0;
    end else if (!iface_enable) begin
      state_r <= ST_HOLD;
      idx_r <= 3'h0;
      exec_start_r <= 1'b0;
    end else begin
      exec_start_r <= 1'b0;
      case (state_r)
        ST_HOLD: begin
          if (tmr_exp) begin
            state_r <= ST_INIT;
          end
        end
        ST_INIT: begin
          idx_r <= 3'h0;
          cmd_r <= 8'h00;
          if (tmr_exp) begin
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE, ST_RECV: begin
          if (ctrl_wr) begin
            state_r <= ST_RECV;
            cmd_r <= wbyte_r;
            idx_r <= 3'h1;
          end else if (go_evt) begin
            idx_r <= 3'h0;
            if (go_valid) begin
              state_r <= ST_EXEC;
              exec_start_r <= 1'b1;
            end else begin
              state_r <= ST_TERM_IDLE;
              term_r <= TERM_INVALID_CMD;
            end
          end else if (data_wr) begin
            idx_r <= idx_r + 3'h1;
          end
        end
        ST_EXEC: begin
          if (exec_done) begin
            term_r <= exec_term;
          end
          if (seek_only) begin
            state_r <= ST_TERM_IDLE;
            term_r <= TERM_OK;
          end else if ((done_seen_r || exec_done) && !fifo_valid && !exec_start_r) begin
            state_r <= ST_TERM_IDLE;
          end
        end
        ST_TERM_IDLE: state_r <= ST_TERM_ATTENTION;
        ST_TERM_ATTENTION: state_r <= ST_TERM_LOAD;
        ST_TERM_LOAD: state_r <= ST_IDLE;
        default: state_r <= ST_HOLD;
      endcase
    end
  end

  // Engine completion is held until the read FIFO drains
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      done_seen_r <= 1'b0;
    end else if (state_r != ST_EXEC) begin
      done_seen_r <= 1'b0;
    end else if (exec_done) begin
      done_seen_r <= 1'b1;
    end
  end

  // Parameter bytes
  generate
    for (genvar i = 1; i <= 6; i++) begin : g_param
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          param_r[i] <= 8'h00;
        end else if (data_wr && (idx_r == 3'(i))) begin
          param_r[i] <= wbyte_r;
        end
      end
      assign op_params[8*i-1 -: 8] = param_r[i];
    end
  endgenerate

  // Auxiliary byte select
  always_comb begin
    case (aux_idx_r)
      4'h1: aux_byte = drive_status;
      4'h2: aux_byte = cmd_r;
      4'h3: aux_byte = {hdr_head, 2'h0, param_r[1][1:0]};
      4'h4: aux_byte = hdr_cyl_lo;
      4'h5: aux_byte = hdr_cyl_hi;
      4'h6: aux_byte = hdr_sector;
      4'h7: aux_byte = hdr_mark;
      default: aux_byte = FILL_BYTE;
    endcase
  end

  // Input buffer loads: echo, termination status, auxiliary status
  assign load_evt = echo_evt || (state_r == ST_TERM_LOAD) || term_rd || aux_rd;
  always_comb begin
    if (echo_evt) begin
      load_byte = wbyte_r;
    end else if (state_r == ST_TERM_LOAD) begin
      load_byte = term_r;
    end else if (term_rd) begin
      load_byte = drive_status;
    end else begin
      load_byte = aux_byte;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      in_buf_r <= 8'h00;
      aux_idx_r <= 4'h0;
    end else if (state_r == ST_INIT) begin
      in_buf_r <= 8'h00;
      aux_idx_r <= 4'h0;
    end else begin
      if (load_evt) begin
        in_buf_r <= load_byte;
      end
      if (term_rd) begin
        aux_idx_r <= 4'h2;
      end else if (aux_rd && aux_idx_r <= AUX_LAST) begin
        aux_idx_r <= aux_idx_r + 4'h1;
      end else if (ctrl_wr) begin
        aux_idx_r <= 4'h0;
      end
    end
  end

  // Input-ready: a load in the same cycle as a read wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      input_ready_r <= 1'b0;
    end else if (state_r == ST_INIT || state_r == ST_HOLD) begin
      input_ready_r <= 1'b0;
    end else if (load_evt) begin
      input_ready_r <= 1'b1;
    end else if (rd_data_evt && !xfer_active) begin
      input_ready_r <= 1'b0;
    end
  end

  // Output-ready: cleared by any write, set once the byte is consumed
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      output_ready_r <= 1'b0;
      consume_r <= 1'b0;
    end else begin
      consume_r <= take_wr;
      if (state_r == ST_HOLD || (state_r == ST_INIT && !tmr_exp)) begin
        output_ready_r <= 1'b0;
      end else if (consume_r || state_r == ST_TERM_LOAD || state_r == ST_INIT) begin
        output_ready_r <= 1'b1;
      end else if (wr_evt) begin
        output_ready_r <= 1'b0;
      end
    end
  end

  // Attention: raised after idle, cleared by the termination read or a control write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      attention_r <= 1'b0;
      term_pending_r <= 1'b0;
    end else if (state_r == ST_HOLD || state_r == ST_INIT) begin
      attention_r <= 1'b0;
      term_pending_r <= 1'b0;
    end else if (state_r == ST_TERM_IDLE) begin
      attention_r <= 1'b1;
    end else if (state_r == ST_TERM_LOAD) begin
      term_pending_r <= 1'b1;
    end else if (term_rd || ctrl_wr) begin
      attention_r <= 1'b0;
      term_pending_r <= 1'b0;
    end
  end

  // Read data path through the FIFO
  dhc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .clr(state_r == ST_HOLD),
    .in_valid(rd_valid && xfer_active),
    .in_ready(rd_ready),
    .in_data(rd_data),
    .out_valid(fifo_valid),
    .out_ready(rd_data_evt && xfer_active),
    .out_data(fifo_data)
  );

  // Command decode
  assign op_class = cmd_r[1:0];
  assign op_code = (op_class == CLASS_NONXFER) ? cmd_r[CMD_CODE_LSB +: 3] : {1'b0, cmd_r[CMD_CODE_LSB +: 2]};
  assign op_seek = cmd_r[CMD_SEEK_BIT] && (op_class != CLASS_NONXFER || op_read_hdr || op_format);
  assign op_retry_en = !cmd_r[CMD_NORETRY_BIT] && !op_direct;
  assign op_track = (op_class != CLASS_NONXFER) && cmd_r[CMD_TRACK_BIT];
  assign op_direct = (op_class != CLASS_NONXFER) && cmd_r[CMD_DIRECT_BIT];
  assign op_addr_chk = (op_class == CLASS_READ) && (op_code[1:0] != C2_NO_ADDR_CHK);
  assign op_data_chk = (op_class == CLASS_READ) && (op_code[1:0] != C2_NO_DATA_CHK);
  assign op_correct = (op_class == CLASS_READ) && (op_code[1:0] == C2_CORRECT);
  assign op_drive_status = (op_class == CLASS_NONXFER) && (op_code == C1_DRIVE_STATUS);
  assign op_read_hdr = (op_class == CLASS_NONXFER) && (op_code == C1_READ_HDR);
  assign op_restore = (op_class == CLASS_NONXFER) && (op_code == C1_RESTORE);
  assign op_format = (op_class == CLASS_NONXFER) && (op_code >= C1_INIT) && (op_code != C1_FAULT_RESET);
  assign op_verify = (op_class == CLASS_NONXFER) && ((op_code == C1_VERIFY) || (op_code == C1_INIT_VFY));
  assign op_fault_reset = (op_class == CLASS_NONXFER) && (op_code == C1_FAULT_RESET);
  assign exec_start = exec_start_r;

  // Status byte and pins
  assign controller_idle_n = (state_r == ST_IDLE) || (state_r == ST_RECV) || (state_r >= ST_TERM_IDLE);
  assign attention = attention_r;
  assign byte_request = xfer_active && fifo_valid;
  assign transfer_direction = (op_class == CLASS_WRITE);
  always_comb begin
    status_byte = 8'h00;
    status_byte[SB_INPUT_READY] = input_ready_r;
    status_byte[SB_OUTPUT_READY] = output_ready_r;
    status_byte[SB_IDLE_N] = controller_idle_n;
    status_byte[SB_BYTE_REQ] = byte_request;
    status_byte[SB_DIR] = transfer_direction;
    status_byte[SB_ATTENTION] = attention_r;
  end
  assign bus_oe = read_strobe;
  assign bus_out = !port_sel ? status_byte : (xfer_active ? fifo_data : in_buf_r);

  // Checks
  a_hold_busy: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == ST_HOLD) |-> !controller_idle_n) else $error("busy not shown during hold");
  a_go_busy: assert property (@(posedge core_clk) disable iff (!nrst)
    (go_evt && go_valid && iface_enable) |=> !controller_idle_n && exec_start) else $error("go did not start");
  a_term_order: assert property (@(posedge core_clk) disable iff (!nrst || !iface_enable)
    (state_r == ST_TERM_IDLE) |-> controller_idle_n && !attention ##1 attention ##1 attention ##1 input_ready_r
    && in_buf_r == term_r) else $error("termination order wrong");
  a_attention_clear: assert property (@(posedge core_clk) disable iff (!nrst || !iface_enable)
    (term_rd && state_r == ST_IDLE) |=> !attention ##1 !attention) else $error("attention not cleared");
  a_echo_byte: assert property (@(posedge core_clk) disable iff (!nrst || !iface_enable)
    echo_evt |=> input_ready_r && (in_buf_r == $past(wbyte_r))) else $error("echo missing");
  a_output_ready_cycle: assert property (@(posedge core_clk) disable iff (!nrst || !iface_enable)
    (take_wr && state_r == ST_RECV && !go_evt) |=> !output_ready_r ##1 output_ready_r)
    else $error("output ready handshake wrong");
  a_input_ready_clear: assert property (@(posedge core_clk) disable iff (!nrst || !iface_enable)
    (rd_data_evt && !load_evt && !xfer_active && state_r != ST_TERM_LOAD) |=> !input_ready_r)
    else $error("input ready not cleared");
  a_status_fmt: assert property (@(posedge core_clk) disable iff (!nrst)
    (read_strobe && !port_sel) |-> bus_oe && bus_out[3:2] == 2'h0 && bus_out[4] == controller_idle_n
    && bus_out[7] == attention) else $error("status byte layout wrong");
  a_restart_cmd: assert property (@(posedge core_clk) disable iff (!nrst || !iface_enable)
    ctrl_wr |=> state_r == ST_RECV && idx_r == 3'h1) else $error("restart failed");
  a_seek_term: assert property (@(posedge core_clk) disable iff (!nrst || !iface_enable)
    (exec_start && seek_only) |=> state_r == ST_TERM_IDLE) else $error("seek did not terminate");
  a_read_dir: assert property (@(posedge core_clk) disable iff (!nrst)
    (exec_start && op_class == CLASS_READ) |-> !transfer_direction) else $error("direction wrong");
  c_go: cover property (@(posedge core_clk) disable iff (!nrst) go_evt && go_valid);
  c_term_read: cover property (@(posedge core_clk) disable iff (!nrst) term_rd);
  c_aux_read: cover property (@(posedge core_clk) disable iff (!nrst) aux_rd && aux_idx_r == AUX_LAST);
  c_fifo_full: cover property (@(posedge core_clk) disable iff (!nrst) xfer_active && !rd_ready);
endmodule // dhc_host_port
`default_nettype wire

// [src/dhc_host_port_fix.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [test/dhc_host_bfm.sv]
`timescale 1ns/1ps
`default_nettype none
// Host side of the strobe bus: one byte per write or read strobe
module dhc_host_bfm (
  input wire logic core_clk,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  output logic [7:0] bus_in,
  output logic write_strobe,
  output logic read_strobe,
  output logic port_sel,
  output logic rd_done,
  output logic [7:0] rd_val
);
  initial begin
    bus_in = 8'h00;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    port_sel = 1'b0;
    rd_done = 1'b0;
    rd_val = 8'h00;
  end
  // Bus held until after the trailing edge, then flipped so no stale byte lingers
  task automatic wr(input logic ps, input logic [7:0] v);
    @(posedge core_clk) #1;
    port_sel = ps;
    bus_in = v;
    write_strobe = 1'b1;
    @(posedge core_clk) #1;
    write_strobe = 1'b0;
    @(posedge core_clk) #1;
    bus_in = ~v;
  endtask
  // Undriven bus reads as high impedance
  task automatic rd(input logic ps, output logic [7:0] v);
    @(posedge core_clk) #1;
    port_sel = ps;
    read_strobe = 1'b1;
    @(negedge core_clk);
    v = bus_oe ? bus_out : 8'hzz;
    rd_val = v;
    @(posedge core_clk) #1;
    read_strobe = 1'b0;
    rd_done = 1'b1;
    @(posedge core_clk) #1;
    rd_done = 1'b0;
  endtask
endmodule // dhc_host_bfm
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dhc_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic iface_enable = 1'b1;
  logic [7:0] bus_in, bus_out, rd_val, rd_data = 8'h00, exec_term = 8'h00, drive_status = 8'h00, cur, b;
  logic write_strobe, read_strobe, port_sel, rd_done, bus_oe, idle_n, attention, byte_request, direction;
  logic exec_start, exec_done = 1'b0, rd_valid = 1'b0, rd_ready, r, saw_full = 1'b0;
  logic [3:0] hdr_head;
  logic [7:0] hdr_cyl_lo, hdr_cyl_hi, hdr_sector, hdr_mark;
  logic [1:0] op_class;
  logic [2:0] op_code;
  logic [15:0] exp_q[$];
  int bad_count = 0;
  int check_count = 0;
  always #5 core_clk = ~core_clk;
  dhc_host_port #(.HOLD_CYC(20), .READY_CYC(30)) dhc_host_port_inst (.core_clk(core_clk), .nrst(nrst),
    .iface_enable(iface_enable), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .port_sel(port_sel), .controller_idle_n(idle_n), .attention(attention),
    .byte_request(byte_request), .transfer_direction(direction), .exec_start(exec_start), .op_class(op_class),
    .op_code(op_code), .op_seek(), .op_retry_en(), .op_track(), .op_direct(), .op_addr_chk(), .op_data_chk(),
    .op_correct(), .op_drive_status(), .op_read_hdr(), .op_restore(), .op_format(), .op_verify(),
    .op_fault_reset(), .op_params(), .exec_done(exec_done), .exec_term(exec_term), .drive_status(drive_status),
    .hdr_head(hdr_head), .hdr_cyl_lo(hdr_cyl_lo), .hdr_cyl_hi(hdr_cyl_hi), .hdr_sector(hdr_sector),
    .hdr_mark(hdr_mark),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready));
  dhc_host_bfm dhc_host_bfm_inst (.core_clk(core_clk), .bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_in),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .port_sel(port_sel), .rd_done(rd_done), .rd_val(rd_val));
  task automatic cmp(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Oldest note is matched against each completed host read while a note is queued
  always @(posedge rd_done) begin
    if (exp_q.size() > 0) begin
      cmp(exp_q[0][7:0], rd_val & exp_q[0][15:8]);
      void'(exp_q.pop_front());
    end
  end
  task automatic note(input logic [7:0] m, input logic [7:0] v, input logic ps);
    logic [7:0] t;
    exp_q.push_back({m, v});
    dhc_host_bfm_inst.rd(ps, t);
  endtask
  task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      dhc_host_bfm_inst.rd(1'b0, s);
      n++;
    end while ((s & m) !== v && n < 300);
    cmp(v, s & m);
  endtask
  task automatic send(input logic [7:0] c, input int n);
    cur = c;
    for (int i = 0; i < n; i++) begin
      b = (i == 0) ? c : 8'($urandom);
      wait_st(8'h12, 8'h12);
      dhc_host_bfm_inst.wr(i != 0, b);
      if (i < 7) begin
        note(8'h1f, 8'h13, 1'b0);
        note(8'hff, b, 1'b1);
        note(8'h01, 8'h00, 1'b0);
      end
    end
  endtask
  task automatic finish(input logic [7:0] t);
    wait_st(8'h90, 8'h90);
    note(8'hff, t, 1'b1);
    note(8'h81, 8'h01, 1'b0);
  endtask
  task automatic rd_cmd(input logic [7:0] c);
    send(c, 8);
    wait_st(8'h70, 8'h20);
    repeat (30) @(posedge core_clk);
    for (int i = 0; i < 20; i++) begin
      wait_st(8'h20, 8'h20);
      note(8'hff, 8'h40 + 8'(i), 1'b1);
    end
    cmp(8'h01, {7'h00, saw_full});
    finish(exec_term);
  endtask
  // Engine stand-in: streams read bytes, stalls on a full buffer, then reports done
  initial forever begin
    @(negedge core_clk);
    if (exec_start !== 1'b1 || (op_class === CLASS_NONXFER && op_code === C1_SEEK)) continue;
    cmp({3'h0, op_class, op_code}, {3'h0, cur[1:0], (cur[1:0] == CLASS_READ) ? {1'b0, cur[3:2]} : cur[4:2]});
    @(posedge core_clk);
    if (op_class === CLASS_READ) begin
      saw_full = 1'b0;
      for (int i = 0; i < 20; i++) begin
        #1 rd_valid = 1'b1;
        rd_data = 8'h40 + 8'(i);
        do begin
          @(negedge core_clk) r = rd_ready;
          saw_full = saw_full | !r;
          @(posedge core_clk);
        end while (!r);
      end
      #1 rd_valid = 1'b0;
    end
    repeat (8) @(posedge core_clk);
    #1 exec_done = 1'b1;
    @(posedge core_clk) #1 exec_done = 1'b0;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400us;
    bad_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'h8ab87d2d));
    drive_status = 8'($urandom);
    {hdr_head, hdr_cyl_lo, hdr_cyl_hi} = 20'($urandom);
    {hdr_sector, hdr_mark} = 16'($urandom);
    repeat (12) @(posedge core_clk);
    #1 nrst = 1'b1;
    note(8'h1c, 8'h00, 1'b0);
    wait_st(8'h1f, 8'h12);
    send(8'h45, 3);
    send(8'h45, 8);
    finish(TERM_OK);
    send(8'h20, 8);
    finish(TERM_INVALID_CMD);
    for (int k = 0; k < 8; k++) begin
      if (k == 1) continue;
      exec_term = 8'($urandom_range(9));
      send({2'($urandom), 1'b0, 3'(k), CLASS_NONXFER}, 8);
      note(8'h10, 8'h00, 1'b0);
      finish(exec_term);
      if (k == 0 || k == 2) note(8'hff, drive_status, 1'b1);
      if (k == 2) begin
        note(8'hff, cur, 1'b1);
        note(8'hf0, {hdr_head, 4'h0}, 1'b1);
        note(8'hff, hdr_cyl_lo, 1'b1);
        note(8'hff, hdr_cyl_hi, 1'b1);
        note(8'hff, hdr_sector, 1'b1);
        note(8'hff, hdr_mark, 1'b1);
        note(8'hff, FILL_BYTE, 1'b1);
      end
    end
    for (int k = 0; k < 4; k++) begin
      exec_term = 8'($urandom_range(9));
      rd_cmd({4'($urandom), 2'(k), CLASS_READ});
    end
    @(posedge core_clk) #1 iface_enable = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 iface_enable = 1'b1;
    note(8'h10, 8'h00, 1'b0);
    wait_st(8'h13, 8'h12);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
